// *** lcc_pkg.sv ***
// Purpose: Shared constants and types for the logic cell cluster.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes: Offsets are byte addresses; each register takes one word.
`default_nettype none

package lcc_pkg;
    // Cluster geometry
    localparam int NUM_CELLS = 10;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register map
    localparam logic [ADDR_W-1:0] CELL_CFG_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] CELL_CFG_LAST = 8'h24;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h28;

    // Status field positions
    localparam int STAT_CARRY_POS = 16;
    localparam int STAT_CASC_POS = 17;
    localparam int STAT_CONFLICT_POS = 18;

    // Reset values
    localparam logic [DATA_W-1:0] CELL_CFG_RST = 32'h0000_0000;

    // Cell operating modes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_ARITH = 2'h1;
    localparam logic [1:0] MODE_COUNTER = 2'h2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Per-cell configuration word
    typedef struct packed {
        logic [5:0] spare;     // Reads back as written, no effect
        logic cin_tap;         // Route carry-in to the cell output
        logic pack_en;         // Register takes operand_in_d directly
        logic fb_en;           // Register feedback into operand A
        logic use_cin;         // Normal mode LUT input 2 is carry-in
        logic ce_sel;          // Which cluster clock enable to use
        logic casc_or;         // Cascade joins by OR instead of AND
        logic casc_en;         // Join LUT result with cascade-in
        logic reg_sel;         // Cell output comes from register
        logic [1:0] mode;      // Operating mode
        logic [15:0] lut_mask; // LUT truth table
    } lcc_cell_cfg_t;

    // Carry and cascade pair between neighbouring clusters
    typedef struct packed {
        logic carry;
        logic cascade;
    } lcc_chain_t;
endpackage : lcc_pkg

`default_nettype wire

// *** lcc_cluster.sv ***
// Purpose: Cluster of ten programmable logic cells with carry and cascade chains.
// Assumes: Data inputs, enables, clear and load come from same-clock routing.
// Notes: Cell configuration is written over AXI4-Lite; status reads cell state.
//
// Contract
// RL1: Ten cells, chains linked in order.
// RL2: Carry-in feeds LUT and next carry.
// RL3: Carry leaves toward next same-parity cluster.
// RL4: n-bit adder fits n+1 cells.
// RL5: Sum selectable direct or registered.
// RL6: Carry-out to next carry-in; last routable.
// RL7: Cascade joins by AND or OR.
// RL8: Each cascaded cell adds four inputs.
// RL9: Cascade leaves toward next same-parity cluster.
// RL10: Two cluster clock enables, selectable per cell.
// RL11: Carry-in use in normal disables packing.
// RL12: Register feedback mux only in first cell.
// RL13: Operands A,B serve counter control except cell two.
// RL14: Clear and load hit all cluster registers.
// RL15: Normal mode four-input LUT, carry or C.
// RL16: Normal LUT joins cascade; packing supported.
// RL17: Arithmetic sum LUT, direct or registered.
// RL18: Arithmetic carry LUT from A,B,carry-in.
// RL19: Arithmetic allows cascade; both outputs driven.
// RL20: Counter: enable, direction, clear, load.
// RL21: Counter cluster shares clear/load; conflict flagged.
// RL22: Clear beats load beats counting.
// RL23: Register updates only when enabled.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`default_nettype none

module lcc_cluster (
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic CLK_EN_I,
    // AXI4-Lite write address
    input wire logic [lcc_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic [2:0] S_AXI_AWPROT_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    // AXI4-Lite write data
    input wire logic [lcc_pkg::DATA_W-1:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // AXI4-Lite read address
    input wire logic [lcc_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic [2:0] S_AXI_ARPROT_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    // AXI4-Lite read data
    output logic [lcc_pkg::DATA_W-1:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    // Cell data inputs from local routing
    input wire logic [lcc_pkg::NUM_CELLS-1:0] OPERAND_IN_A_I,
    input wire logic [lcc_pkg::NUM_CELLS-1:0] OPERAND_IN_B_I,
    input wire logic [lcc_pkg::NUM_CELLS-1:0] OPERAND_IN_C_I,
    input wire logic [lcc_pkg::NUM_CELLS-1:0] OPERAND_IN_D_I,
    // Cluster-wide controls
    input wire logic [1:0] CLUSTER_CE_I,
    input wire logic SYNC_CLEAR_I,
    input wire logic SYNC_LOAD_I,
    // Chains from and to the same-parity neighbour clusters
    input wire lcc_pkg::lcc_chain_t CHAIN_IN_I,
    output lcc_pkg::lcc_chain_t CHAIN_OUT_O,
    // Cell results
    output logic [lcc_pkg::NUM_CELLS-1:0] CELL_COMB_O,
    output logic [lcc_pkg::NUM_CELLS-1:0] CELL_REG_O,
    output logic [lcc_pkg::NUM_CELLS-1:0] CELL_OUT_O
);

    localparam int N = lcc_pkg::NUM_CELLS;

    // Three-input LUT lookup, used by sum and carry halves
    function automatic logic lut3(input logic [7:0] mask, input logic [2:0] idx);
        lut3 = mask[idx];
    endfunction : lut3

    // Configuration storage, one word per cell
    lcc_pkg::lcc_cell_cfg_t cfg_q [N];

    // Chain nets, index i is the input to cell i
    logic [N:0] carry_w;
    logic [N:0] casc_w;
    logic [N-1:0] cell_q;          // Cell registers
    logic [N-1:0] comb_w;          // Unregistered cell result
    logic [N-1:0] cnt_cell_w;      // Cell runs in counter mode
    logic [N-1:0] reg_used_w;      // Cell register is in use

    // Bus state
    logic aw_full_q;               // Write address held
    logic w_full_q;                // Write data held
    logic [lcc_pkg::ADDR_W-1:0] aw_addr_q;
    logic [lcc_pkg::DATA_W-1:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [lcc_pkg::DATA_W-1:0] rdata_q;

    // RL1: chain entry
    // Chains enter at cell one from the neighbouring cluster
    assign carry_w[0] = CHAIN_IN_I.carry;
    assign casc_w[0] = CHAIN_IN_I.cascade;

    // RL3: carry leaves cluster
    // RL9: cascade leaves cluster
    // Last cell drives the port wired two clusters onward
    assign CHAIN_OUT_O.carry = carry_w[N];
    assign CHAIN_OUT_O.cascade = casc_w[N];

    // Ten cells in chain order
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_cell
            lcc_pkg::lcc_cell_cfg_t cfg_w;
            logic op_a_w;          // Operand A after feedback mux
            logic cin_w;           // Carry into this cell
            logic lut4_w;          // Normal mode LUT result
            logic sum_w;           // Arithmetic first LUT
            logic arith_cout_w;    // Arithmetic second LUT
            logic lut_w;           // LUT result for this mode
            logic casc_out_w;      // Cascade toward next cell
            logic cnt_en_w;        // Counter enable
            logic cnt_up_w;        // Counter direction
            logic cnt_cout_w;      // Counter carry toward next bit
            logic pack_ok_w;       // Packing allowed
            logic ce_w;            // Selected enable
            logic d_w;             // Register next value

            assign cfg_w = cfg_q[gi];
            assign cin_w = carry_w[gi];

            // RL12: feedback mux
            // Only the first cell can loop its register into operand A
            if (gi == 0) begin : g_fb
                assign op_a_w = cfg_w.fb_en ? cell_q[gi] : OPERAND_IN_A_I[gi];
            end else begin : g_nofb
                assign op_a_w = OPERAND_IN_A_I[gi];
            end

            // RL15: four-input LUT
            // RL2: carry-in into LUT
            // Input two is carry-in or operand C
            assign lut4_w = cfg_w.lut_mask[{OPERAND_IN_D_I[gi],
                (cfg_w.use_cin ? cin_w : OPERAND_IN_C_I[gi]),
                OPERAND_IN_B_I[gi], op_a_w}];

            // RL17: sum LUT
            // Lower eight mask bits give f(carry-in, B, A)
            assign sum_w = lut3(cfg_w.lut_mask[7:0], {cin_w, OPERAND_IN_B_I[gi], op_a_w});

            // RL18: carry LUT
            // Upper eight mask bits give carry-out from the same three signals
            assign arith_cout_w = lut3(cfg_w.lut_mask[15:8],
                {cin_w, OPERAND_IN_B_I[gi], op_a_w});

            // LUT result for the chosen mode
            assign lut_w = (cfg_w.mode == lcc_pkg::MODE_ARITH) ? sum_w : lut4_w;

            // RL7: AND or OR join
            // RL16: normal cascade
            // RL19: arithmetic cascade
            // RL8: four inputs per cell
            // casc_or picks OR or AND of the LUT result and cascade-in; with casc_en off the LUT result passes alone
            assign casc_out_w = !cfg_w.casc_en ? lut_w :
                (cfg_w.casc_or ? (lut_w | casc_w[gi]) : (lut_w & casc_w[gi]));
            assign casc_w[gi+1] = casc_out_w;

            // RL13: counter controls
            // The second cell cannot take control from A and B; it counts up
            if (gi == 1) begin : g_cnt_fixed
                assign cnt_en_w = 1'b1;
                assign cnt_up_w = 1'b1;
            end else begin : g_cnt_ops
                assign cnt_en_w = op_a_w;
                assign cnt_up_w = OPERAND_IN_B_I[gi];
            end

            // Counter bit toggles when carry-in says lower bits roll over
            assign cnt_cout_w = cnt_en_w & cin_w &
                (cnt_up_w ? cell_q[gi] : ~cell_q[gi]);

            // RL6: carry to next cell
            // RL2: carry onward
            // Normal mode passes no carry
            assign carry_w[gi+1] =
                (cfg_w.mode == lcc_pkg::MODE_ARITH) ? arith_cout_w :
                (cfg_w.mode == lcc_pkg::MODE_COUNTER) ? cnt_cout_w :
                1'b0;

            // RL11: no packing with carry-in
            assign pack_ok_w = cfg_w.pack_en &
                !(cfg_w.mode == lcc_pkg::MODE_NORMAL && cfg_w.use_cin);

            // RL4: final carry tap
            // An extra cell can carry the chain's last carry out as data
            assign comb_w[gi] = cfg_w.cin_tap ? cin_w : casc_out_w;

            // RL10: enable selection
            assign ce_w = CLK_EN_I & CLUSTER_CE_I[cfg_w.ce_sel];

            // RL22: clear, load, count
            // RL14: shared clear and load
            // RL20: counter operations
            always_comb begin
                if (SYNC_CLEAR_I) begin
                    d_w = 1'b0;
                end else if (SYNC_LOAD_I) begin
                    d_w = OPERAND_IN_C_I[gi];
                end else if (cfg_w.mode == lcc_pkg::MODE_COUNTER) begin
                    d_w = cell_q[gi] ^ (cnt_en_w & cin_w);
                end else if (pack_ok_w) begin
                    // Packed register takes operand D alone
                    d_w = OPERAND_IN_D_I[gi];
                end else begin
                    d_w = comb_w[gi];
                end
            end

            // RL23: enabled update
            // Cell register
            always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
                if (!RESET_N_I) begin
                    cell_q[gi] <= 1'b0;
                end else if (ce_w) begin
                    cell_q[gi] <= d_w;
                end
            end

            // Register use for the sharing check
            assign cnt_cell_w[gi] = (cfg_w.mode == lcc_pkg::MODE_COUNTER);
            assign reg_used_w[gi] = cfg_w.reg_sel | pack_ok_w;

            // RL5: direct or registered
            // RL19: both results out
            assign CELL_COMB_O[gi] = comb_w[gi];
            assign CELL_REG_O[gi] = cell_q[gi];
            assign CELL_OUT_O[gi] = cfg_w.reg_sel ? cell_q[gi] : comb_w[gi];
        end
    endgenerate

    // RL21: sharing conflict
    // Registered non-counter cells beside a counter see its clear and load
    logic conflict_w;
    assign conflict_w = (|cnt_cell_w) & (|(reg_used_w & ~cnt_cell_w));

    // Write address decode
    logic wr_go_w;
    logic wr_hit_w;
    logic [3:0] wr_idx_w;
    assign wr_go_w = CLK_EN_I & aw_full_q & w_full_q & !bvalid_q;
    assign wr_hit_w = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q <= lcc_pkg::CELL_CFG_LAST);
    assign wr_idx_w = aw_addr_q[5:2];

    // Handshake outputs
    assign S_AXI_AWREADY_O = CLK_EN_I & !aw_full_q;
    assign S_AXI_WREADY_O = CLK_EN_I & !w_full_q;
    assign S_AXI_ARREADY_O = CLK_EN_I & !rvalid_q;
    assign S_AXI_BVALID_O = bvalid_q;
    assign S_AXI_BRESP_O = bresp_q;
    assign S_AXI_RVALID_O = rvalid_q;
    assign S_AXI_RRESP_O = rresp_q;
    assign S_AXI_RDATA_O = rdata_q;

    // Write address and data capture, in either order
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= 4'h0;
        end else if (CLK_EN_I) begin
            if (S_AXI_AWVALID_I && !aw_full_q) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR_I;
            end else if (wr_go_w) begin
                aw_full_q <= 1'b0;
            end
            if (S_AXI_WVALID_I && !w_full_q) begin
                w_full_q <= 1'b1;
                w_data_q <= S_AXI_WDATA_I;
                w_strb_q <= S_AXI_WSTRB_I;
            end else if (wr_go_w) begin
                w_full_q <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            bvalid_q <= 1'b0;
            bresp_q <= lcc_pkg::RESP_OKAY;
        end else if (CLK_EN_I) begin
            if (wr_go_w) begin
                bvalid_q <= 1'b1;
                bresp_q <= (wr_hit_w || aw_addr_q == lcc_pkg::STATUS_OFS) ?
                    lcc_pkg::RESP_OKAY : lcc_pkg::RESP_SLVERR;
            end else if (S_AXI_BREADY_I) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Configuration words, byte lanes honoured
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            for (int i = 0; i < N; i++) begin
                cfg_q[i] <= lcc_pkg::CELL_CFG_RST;
            end
        end else if (wr_go_w && wr_hit_w) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb_q[b]) begin
                    cfg_q[wr_idx_w][b*8 +: 8] <= w_data_q[b*8 +: 8];
                end
            end
        end
    end

    // Read decode
    logic [3:0] rd_idx_w;
    logic rd_cfg_w;
    logic rd_stat_w;
    logic [lcc_pkg::DATA_W-1:0] stat_w;
    assign rd_idx_w = S_AXI_ARADDR_I[5:2];
    assign rd_cfg_w = (S_AXI_ARADDR_I[1:0] == 2'h0) &&
        (S_AXI_ARADDR_I <= lcc_pkg::CELL_CFG_LAST);
    assign rd_stat_w = (S_AXI_ARADDR_I == lcc_pkg::STATUS_OFS);

    // Status word: register bits, chain outputs, conflict flag
    always_comb begin
        stat_w = '0;
        stat_w[N-1:0] = cell_q;
        stat_w[lcc_pkg::STAT_CARRY_POS] = carry_w[N];
        stat_w[lcc_pkg::STAT_CASC_POS] = casc_w[N];
        stat_w[lcc_pkg::STAT_CONFLICT_POS] = conflict_w;
    end

    // Read channel, one outstanding read
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rvalid_q <= 1'b0;
            rresp_q <= lcc_pkg::RESP_OKAY;
            rdata_q <= '0;
        end else if (CLK_EN_I) begin
            if (S_AXI_ARVALID_I && !rvalid_q) begin
                rvalid_q <= 1'b1;
                if (rd_cfg_w) begin
                    rdata_q <= cfg_q[rd_idx_w];
                    rresp_q <= lcc_pkg::RESP_OKAY;
                end else if (rd_stat_w) begin
                    rdata_q <= stat_w;
                    rresp_q <= lcc_pkg::RESP_OKAY;
                end else begin
                    // Unmapped: zero data, slave error
                    rdata_q <= '0;
                    rresp_q <= lcc_pkg::RESP_SLVERR;
                end
            end else if (S_AXI_RREADY_I) begin
                rvalid_q <= 1'b0;
            end
        end
    end

endmodule : lcc_cluster

`default_nettype wire

// *** lcc_nbr.sv ***
// Purpose: Neighbour cluster two places down, feeding the chain inputs.
// Assumes: Shares the reference clock with the cluster under test.
// Notes: Its last cell hands carry and cascade on through a register.
`default_nettype none

module lcc_nbr (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic carry_i,
    input wire logic casc_i,
    output var lcc_pkg::lcc_chain_t chain_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chain_o <= '0;
        end else begin
            chain_o <= '{carry: carry_i, cascade: casc_i};
        end
    end
endmodule : lcc_nbr

`default_nettype wire

// *** lcc_cluster_sva.sv ***
// Purpose: Port checker for the logic cell cluster.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound onto every cluster instance.
`default_nettype none

module lcc_cluster_chk (
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic CLK_EN_I,
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0] S_AXI_RRESP_O,
    input wire logic [9:0] OPERAND_IN_C_I,
    input wire logic [1:0] CLUSTER_CE_I,
    input wire logic SYNC_CLEAR_I,
    input wire logic SYNC_LOAD_I,
    input wire logic [9:0] CELL_COMB_O,
    input wire logic [9:0] CELL_REG_O,
    input wire logic [9:0] CELL_OUT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    // Both cluster enables up, so every cell is enabled
    wire logic all_en = CLK_EN_I && (CLUSTER_CE_I == 2'h3);
    // Read address taken
    wire logic ar_hs = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

    property p_b_lat;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
            |-> ##[1:3] S_AXI_BVALID_O;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write response late");
    property p_r_lat;
        ar_hs |=> S_AXI_RVALID_O;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read data late");
    property p_r_err;
        ar_hs && S_AXI_ARADDR_I > lcc_pkg::STATUS_OFS
            |=> S_AXI_RRESP_O == lcc_pkg::RESP_SLVERR && S_AXI_RDATA_O == '0;
    endproperty
    a_r_err: assert property (p_r_err) else $error("unmapped read not refused");
    property p_ar_blk;
        S_AXI_RVALID_O |-> !S_AXI_ARREADY_O;
    endproperty
    a_ar_blk: assert property (p_ar_blk) else $error("read taken while busy");
    property p_en_off;
        !CLK_EN_I |-> !(S_AXI_AWREADY_O || S_AXI_WREADY_O || S_AXI_ARREADY_O);
    endproperty
    a_en_off: assert property (p_en_off) else $error("bus ready while frozen");
    property p_hold;
        !CLK_EN_I || CLUSTER_CE_I == 2'h0 |=> $stable(CELL_REG_O);
    endproperty
    a_hold: assert property (p_hold) else $error("register moved while disabled");
    property p_clear;
        all_en && SYNC_CLEAR_I |=> CELL_REG_O == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear missed");
    property p_load;
        all_en && SYNC_LOAD_I && !SYNC_CLEAR_I |=> CELL_REG_O == $past(OPERAND_IN_C_I);
    endproperty
    a_load: assert property (p_load) else $error("load missed");
    property p_out;
        ((CELL_OUT_O ^ CELL_COMB_O) & (CELL_OUT_O ^ CELL_REG_O)) == '0;
    endproperty
    a_out: assert property (p_out) else $error("output from neither source");
    c_clear: cover property (all_en && SYNC_CLEAR_I && SYNC_LOAD_I);
    c_rerr: cover property (S_AXI_RVALID_O && S_AXI_RRESP_O == lcc_pkg::RESP_SLVERR);
    c_frozen: cover property (!CLK_EN_I);
endmodule : lcc_cluster_chk

bind lcc_cluster lcc_cluster_chk i_lcc_cluster_chk (.*);

`default_nettype wire

// *** tb.sv ***
// Purpose: Self-checking bench for the logic cell cluster.
// Assumes: Bus and cell timing as in the designer's hand-over.
// Notes: A neighbour model feeds the chain inputs.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic REF_CLK_I = 1'b0, RESET_N_I = 1'b0, CLK_EN_I = 1'b1;
    logic [7:0] S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00;
    logic [2:0] S_AXI_AWPROT_I = 3'h0, S_AXI_ARPROT_I = 3'h0;
    logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O;
    logic [3:0] S_AXI_WSTRB_I = 4'hF;
    logic S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0, S_AXI_BREADY_I = 1'b0;
    logic S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0, SYNC_CLEAR_I = 1'b0;
    logic SYNC_LOAD_I = 1'b0, S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O;
    logic S_AXI_ARREADY_O, S_AXI_RVALID_O;
    logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, CLUSTER_CE_I = 2'h0;
    logic [9:0] OPERAND_IN_A_I = '0, OPERAND_IN_B_I = '0;
    logic [9:0] OPERAND_IN_C_I = '0, OPERAND_IN_D_I = '0;
    logic [9:0] CELL_COMB_O, CELL_REG_O, CELL_OUT_O;
    lcc_pkg::lcc_chain_t CHAIN_IN_I, CHAIN_OUT_O;
    logic nbr_carry = 1'b0, nbr_casc = 1'b0; // Neighbour requests
    logic [31:0] rd; // Last read data
    logic [1:0] rr; // Last response
    int failures = 0, checked = 0;

    // Clock at 100 MHz
    always #5 REF_CLK_I = ~REF_CLK_I;

    lcc_cluster i_lcc_cluster (.*);
    lcc_nbr i_lcc_nbr (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESET_N_I),
        .carry_i(nbr_carry),
        .casc_i(nbr_casc),
        .chain_o(CHAIN_IN_I)
    );

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task give_verdict;
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // One bus transfer; handshakes judged just before each edge
    task axi(input logic wr, input logic [7:0] a, input logic [31:0] di,
             output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ha, hw, hr, done;
        n = 0;
        done = 1'b0;
        @(posedge REF_CLK_I);
        S_AXI_AWADDR_I <= a;
        S_AXI_ARADDR_I <= a;
        S_AXI_WDATA_I <= di;
        S_AXI_AWVALID_I <= wr;
        S_AXI_WVALID_I <= wr;
        S_AXI_BREADY_I <= wr;
        S_AXI_ARVALID_I <= !wr;
        S_AXI_RREADY_I <= !wr;
        while (!done && n < 50) begin
            @(negedge REF_CLK_I);
            ha = S_AXI_AWREADY_O;
            hw = S_AXI_WREADY_O;
            hr = S_AXI_ARREADY_O;
            done = wr ? S_AXI_BVALID_O : S_AXI_RVALID_O;
            r = wr ? S_AXI_BRESP_O : S_AXI_RRESP_O;
            d = S_AXI_RDATA_O;
            @(posedge REF_CLK_I);
            if (ha) S_AXI_AWVALID_I <= 1'b0;
            if (hw) S_AXI_WVALID_I <= 1'b0;
            if (hr) S_AXI_ARVALID_I <= 1'b0;
            n++;
        end
        S_AXI_BREADY_I <= 1'b0;
        S_AXI_RREADY_I <= 1'b0;
        if (!done) failures++;
    endtask : axi

    // Same configuration word into all ten cells
    task cfg_all(input logic [31:0] v);
        for (int i = 0; i < lcc_pkg::NUM_CELLS; i++) begin
            axi(1'b1, 8'(4 * i), v, rd, rr);
            chk(32'(rr), 32'(lcc_pkg::RESP_OKAY));
        end
    endtask : cfg_all

    // Operands and chain requests, then two edges through the neighbour
    task drive(input logic [9:0] a, input logic [9:0] b, input logic ci, input logic cs);
        @(posedge REF_CLK_I);
        OPERAND_IN_A_I <= a;
        OPERAND_IN_B_I <= b;
        nbr_carry <= ci;
        nbr_casc <= cs;
        repeat (2) @(posedge REF_CLK_I);
        #1;
    endtask : drive

    // One clock of enables, clear and load
    task pulse(input logic [1:0] ce, input logic cl, input logic ld);
        @(posedge REF_CLK_I);
        CLUSTER_CE_I <= ce;
        SYNC_CLEAR_I <= cl;
        SYNC_LOAD_I <= ld;
        @(posedge REF_CLK_I);
        CLUSTER_CE_I <= 2'h0;
        SYNC_CLEAR_I <= 1'b0;
        SYNC_LOAD_I <= 1'b0;
        #1;
    endtask : pulse

    // Reset value, read-back, refused and read-only places
    task s_regs;
        axi(1'b0, 8'h00, 32'h0, rd, rr);
        chk(rd, lcc_pkg::CELL_CFG_RST);
        axi(1'b1, 8'h0C, 32'hFC0A_5A5A, rd, rr);
        axi(1'b0, 8'h0C, 32'h0, rd, rr);
        chk(rd, 32'hFC0A_5A5A);
        axi(1'b1, 8'h2C, 32'hFFFF_FFFF, rd, rr);
        chk(32'(rr), 32'(lcc_pkg::RESP_SLVERR));
        axi(1'b0, 8'h30, 32'h0, rd, rr);
        chk(rd, 32'h0);
        axi(1'b1, lcc_pkg::STATUS_OFS, 32'h0, rd, rr);
        chk(32'(rr), 32'(lcc_pkg::RESP_OKAY));
    endtask : s_regs

    task s_casc;
        cfg_all(32'h0008_AAAA);
        drive(10'h3FF, 10'h000, 1'b0, 1'b1);
        chk(32'({CHAIN_OUT_O, CELL_COMB_O}), 32'h7FF);
        drive(10'h3FE, 10'h000, 1'b0, 1'b1);
        chk(32'({CHAIN_OUT_O, CELL_COMB_O}), 32'h000);
        cfg_all(32'h0018_AAAA);
        drive(10'h010, 10'h000, 1'b0, 1'b0);
        chk(32'({CHAIN_OUT_O, CELL_COMB_O}), 32'h7F0);
    endtask : s_casc

    task s_add;
        cfg_all(32'h0005_E896);
        drive(10'h3FF, 10'h001, 1'b0, 1'b0);
        chk(32'({CHAIN_OUT_O.carry, CELL_COMB_O}), 32'h400);
        drive(10'h155, 10'h0AA, 1'b1, 1'b0);
        chk(32'({CHAIN_OUT_O.carry, CELL_COMB_O}), 32'h200);
        pulse(2'h3, 1'b0, 1'b0);
        chk(32'({CELL_REG_O, CELL_OUT_O}), 32'h80200);
        axi(1'b0, lcc_pkg::STATUS_OFS, 32'h0, rd, rr);
        chk(rd & 32'h0001_03FF, 32'h0000_0200);
    endtask : s_add

    task s_ctl;
        OPERAND_IN_C_I <= 10'h2A5;
        pulse(2'h3, 1'b0, 1'b1);
        chk(32'(CELL_REG_O), 32'h2A5);
        pulse(2'h3, 1'b1, 1'b1);
        chk(32'(CELL_REG_O), 32'h000);
        pulse(2'h3, 1'b0, 1'b1);
        pulse(2'h2, 1'b1, 1'b0);
        chk(32'(CELL_REG_O), 32'h2A5);
        @(posedge REF_CLK_I);
        CLK_EN_I <= 1'b0;
        pulse(2'h3, 1'b1, 1'b0);
        chk(32'(CELL_REG_O), 32'h2A5);
        @(posedge REF_CLK_I);
        CLK_EN_I <= 1'b1;
    endtask : s_ctl

    task s_cnt;
        axi(1'b1, 8'h00, 32'h0006_0000, rd, rr);
        drive(10'h001, 10'h001, 1'b1, 1'b0);
        pulse(2'h3, 1'b1, 1'b0);
        pulse(2'h3, 1'b0, 1'b0);
        chk(32'(CELL_REG_O[0]), 32'h1);
        pulse(2'h3, 1'b0, 1'b0);
        chk(32'(CELL_REG_O[0]), 32'h0);
        axi(1'b0, lcc_pkg::STATUS_OFS, 32'h0, rd, rr);
        chk(32'(rd[lcc_pkg::STAT_CONFLICT_POS]), 32'h1);
    endtask : s_cnt

    // carry LUT input, packing, feedback, carry tap
    task s_opt;
        axi(1'b1, 8'h00, 32'h0140_F0F0, rd, rr);
        drive(10'h000, 10'h000, 1'b1, 1'b0);
        chk(32'(CELL_COMB_O[0]), 32'h1);
        pulse(2'h3, 1'b0, 1'b0);
        chk(32'(CELL_REG_O[0]), 32'h1);
        axi(1'b1, 8'h00, 32'h0080_5555, rd, rr);
        pulse(2'h3, 1'b0, 1'b0);
        chk(32'(CELL_REG_O[0]), 32'h0);
        axi(1'b1, 8'h24, 32'h0200_0000, rd, rr);
        drive(10'h1FE, 10'h002, 1'b0, 1'b0);
        chk(32'(CELL_COMB_O), 32'h201);
    endtask : s_opt

    // Main sequence
    initial begin
        repeat (20) @(posedge REF_CLK_I);
        RESET_N_I <= 1'b1;
        s_regs();
        s_casc();
        s_add();
        s_ctl();
        s_cnt();
        s_opt();
        give_verdict();
    end

    // Watchdog against a hung handshake
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
endmodule : tb

`default_nettype wire
